// File: rtl/cache_chan_write.sv
// cache logic serving a channel write to main memory
// Contract
// R1 - controllers request; arbiter picks one, raises combined request, selects it
// R2 - combined request synchronised into precycle, which loads the address latch
// R3 - cycle starts only unlocked, no read-pause write, no I/O-map precycle
// R4 - start raises channel cycle and lock; lock blocks other service
// R5 - latched address muxed out; bits 9:2 index, 21:10 compare tags
// R6 - a write hit in either way invalidates that way's block
// R7 - at T30 disable arbitration and send data select to winner
// R8 - write data goes on the memory bus only once it is unoccupied
// R9 - at T60 broadcast request acknowledge to all controllers
// R10 - at T120 pulse the priority clock to record the winner
// R11 - at T150 drop the disable; the arbiter stays held by lock until finish, and arbitration resumes only then
// R12 - at T180 slow cycle; start strobe 100 ns after bus free
// R13 - memory acknowledge returns an address acknowledge to controllers
// R14 - acknowledge stops timeout; tag write only when a hit occurred
// R15 - then restart and finish release lock and channel cycle
// R16 - latch captures 22 address and three control bits on latch clock
// R17 - mux select: cpu 00, power-up 01, channel 10, I/O map 11
// R18 - power-up counter 0..255 clears both tag ways with good parity
// R19 - bit 1 selects word, bit 0 selects byte on byte writes
// R20 - memory op bit 1 stays low; bit 0 is the selected C1
// R21 - missing memory acknowledge ends in timeout and an error flag
`timescale 1ns/100ps
module cache_chan_write #(
    parameter int N = 4,
    parameter int DATA_W = 36,
    parameter int TMO_CYC = cache_wr_pkg::CYC_TMO
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] chan_req_i,
    input wire logic [21:0] chan_addr_i,
    input wire logic chan_c1_i,
    input wire logic chan_c0_i,
    input wire logic extra_op_control_bit_i,
    input wire logic [DATA_W-1:0] chan_wdata_i,
    input wire logic [21:0] cpu_addr_i,
    input wire logic [21:0] iomap_addr_i,
    input wire logic iomap_cycle_i,
    input wire logic read_pause_write_i,
    input wire logic iomap_precycle_i,
    input wire logic memory_bus_occupied_i,
    input wire logic main_ack_i,
    output logic [N-1:0] address_select_to_winner_o,
    output logic [N-1:0] data_select_o,
    output logic channel_combined_request_o,
    output logic channel_request_ack_o,
    output logic priority_record_clock_o,
    output logic arb_disable_o,
    output logic channel_cycle_active_o,
    output logic cycle_lock_o,
    output logic addr_mux_select_high_o,
    output logic addr_mux_select_low_o,
    output logic [21:0] mem_addr_o,
    output logic memory_bus_op_bit1_o,
    output logic memory_bus_op_bit0_o,
    output logic word_select_o,
    output logic byte_select_o,
    output logic byte_write_op_o,
    output logic [DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    output logic slow_cycle_o,
    output logic mem_start_o,
    output logic requester_address_ack_o,
    output logic tag_write_o,
    output logic timeout_err_o,
    output logic init_busy_o
);
    localparam int D30 = cache_wr_pkg::CYC_T30;
    localparam int D60 = cache_wr_pkg::CYC_T60;
    localparam int D120 = cache_wr_pkg::CYC_T120;
    localparam int D150 = cache_wr_pkg::CYC_T150;
    localparam int D180 = cache_wr_pkg::CYC_T180;
    localparam int DSKEW = cache_wr_pkg::CYC_SKEW;

    typedef enum logic [2:0] {
        S_IDLE, S_SEQ, S_SLOW, S_ACK, S_DONE
    } state_t;
    state_t state_r;

    // pin synchronisers
    logic [N-1:0] req_m, req_s;
    logic [21:0] addr_m, addr_s;
    logic [2:0] ctl_m, ctl_s;
    logic [DATA_W-1:0] wd_m, wd_s;
    logic occ_m, occ_s, ack_m, ack_s;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_m <= '0;
            req_s <= '0;
            addr_m <= '0;
            addr_s <= '0;
            ctl_m <= '0;
            ctl_s <= '0;
            wd_m <= '0;
            wd_s <= '0;
            occ_m <= 1'b1;
            occ_s <= 1'b1;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end else begin
            req_m <= chan_req_i;
            req_s <= req_m;
            addr_m <= chan_addr_i;
            addr_s <= addr_m;
            ctl_m <= {chan_c1_i, chan_c0_i, extra_op_control_bit_i};
            ctl_s <= ctl_m;
            wd_m <= chan_wdata_i;
            wd_s <= wd_m;
            occ_m <= memory_bus_occupied_i;
            occ_s <= occ_m;
            ack_m <= main_ack_i;
            ack_s <= ack_m;
        end
    end

    // arbitration
    logic [N-1:0] grant;
    logic any_req;
    logic dis_r, prio_r, rack_r, pre_r, lock_r;
    channel_arbiter #(.N(N)) u_arb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req_s),
        .disable_i(dis_r | lock_r),
        .prio_clk_i(prio_r),
        .grant_o(grant),
        .any_o(any_req)
    ); // see R1 see R10

    // precycle, start decision and address latch
    logic [21:0] lat_addr_r;
    logic [2:0] lat_ctl_r;
    logic start_ok, latch_clk, grant_steady;
    logic [1:0] pre_sh_r;
    assign grant_steady = any_req && |(grant & req_s)
        && grant == address_select_to_winner_o;
    assign latch_clk = pre_r && !lock_r; // see R16
    assign start_ok = pre_r && !lock_r && !read_pause_write_i
        && !iomap_precycle_i && !init_busy_o; // see R3

    // power-up tag clear
    logic [7:0] init_cnt_r;
    logic init_r;

    // address multiplexer
    logic [1:0] sel;
    logic [21:0] mux_addr, init_addr;
    logic mux_c1;
    assign sel = init_r ? cache_wr_pkg::SEL_INIT
        : lock_r ? cache_wr_pkg::SEL_CHAN
        : iomap_cycle_i ? cache_wr_pkg::SEL_IOMAP
        : cache_wr_pkg::SEL_CPU; // see R17
    assign init_addr = {12'h0000, init_cnt_r, 2'h0};
    assign mux_addr = (sel == cache_wr_pkg::SEL_INIT) ? init_addr
        : (sel == cache_wr_pkg::SEL_CHAN) ? lat_addr_r
        : (sel == cache_wr_pkg::SEL_IOMAP) ? iomap_addr_i
        : cpu_addr_i; // see R5
    assign mux_c1 = (sel == cache_wr_pkg::SEL_CHAN) && lat_ctl_r[2];

    // tag lookup and entry build
    logic [7:0] idx;
    logic [11:0] tag_in;
    logic [14:0] rd0, rd1, new_ent;
    logic [1:0] hit, tag_wr, hit_r;
    logic twr_r;
    assign idx = mux_addr[cache_wr_pkg::IDX_HI:cache_wr_pkg::IDX_LO];
    assign tag_in = mux_addr[cache_wr_pkg::TAG_HI:cache_wr_pkg::TAG_LO];
    assign hit[0] = rd0[cache_wr_pkg::ENT_VALID]
        && rd0[11:0] == tag_in; // see R5
    assign hit[1] = rd1[cache_wr_pkg::ENT_VALID]
        && rd1[11:0] == tag_in;
    assign new_ent = {1'b0,
        ~^mux_addr[cache_wr_pkg::TAG_HI:cache_wr_pkg::PA_LO],
        ~^mux_addr[cache_wr_pkg::PA_LO-1:cache_wr_pkg::TAG_LO],
        tag_in}; // see R18
    assign tag_wr = init_r ? 2'h3
        : (twr_r ? hit_r : 2'h0); // see R6 see R14
    tag_store u_tags (
        .clk_i(clk_i),
        .idx_i(idx),
        .wr_i(tag_wr),
        .wdata_i(new_ent),
        .rd0_o(rd0),
        .rd1_o(rd1)
    );

    // step and wait counters
    logic [7:0] step_r, skew_r;
    logic [31:0] tmo_r;
    logic at30, at60, at120, at150, at180, skew_done, tmo_done;
    assign at30 = state_r == S_SEQ && step_r == 8'(D30 - 1);
    assign at60 = state_r == S_SEQ && step_r == 8'(D60 - 1);
    assign at120 = state_r == S_SEQ && step_r == 8'(D120 - 1);
    assign at150 = state_r == S_SEQ && step_r == 8'(D150 - 1);
    assign at180 = state_r == S_SEQ && step_r == 8'(D180 - 1);
    assign skew_done = !occ_s && skew_r == 8'(DSKEW - 1);
    assign tmo_done = tmo_r == 32'(TMO_CYC - 1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_r <= 1'b1;
            init_cnt_r <= cache_wr_pkg::INIT_FIRST;
        end else if (init_r) begin
            init_cnt_r <= init_cnt_r + 8'h01;
            init_r <= init_cnt_r != cache_wr_pkg::INIT_LAST; // see R18
        end
    end

    // cycle sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            step_r <= '0;
            skew_r <= '0;
            tmo_r <= '0;
            lock_r <= 1'b0;
            hit_r <= '0;
            twr_r <= 1'b0;
            requester_address_ack_o <= 1'b0;
            tag_write_o <= 1'b0;
            mem_start_o <= 1'b0;
            slow_cycle_o <= 1'b0;
            timeout_err_o <= 1'b0;
        end else begin
            twr_r <= 1'b0;
            tag_write_o <= 1'b0;
            requester_address_ack_o <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    if (start_ok) begin
                        state_r <= S_SEQ;
                        lock_r <= 1'b1; // see R4
                        step_r <= '0;
                    end
                end
                S_SEQ: begin
                    step_r <= step_r + 8'h01;
                    if (step_r == '0) begin
                        hit_r <= hit; // see R6
                    end
                    if (at180) begin
                        state_r <= S_SLOW;
                        slow_cycle_o <= 1'b1; // see R12
                        skew_r <= '0;
                    end
                end
                S_SLOW: begin
                    skew_r <= occ_s ? 8'h00 : skew_r + 8'h01;
                    if (skew_done) begin
                        state_r <= S_ACK;
                        mem_start_o <= 1'b1; // see R12
                        tmo_r <= '0;
                    end
                end
                S_ACK: begin
                    tmo_r <= tmo_r + 32'h0000_0001;
                    if (ack_s) begin
                        mem_start_o <= 1'b0;
                        requester_address_ack_o <= 1'b1; // see R13
                        twr_r <= |hit_r; // see R14
                        tag_write_o <= |hit_r;
                        state_r <= S_DONE;
                    end else if (tmo_done) begin
                        mem_start_o <= 1'b0;
                        timeout_err_o <= 1'b1; // see R21
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    lock_r <= 1'b0; // see R15
                    slow_cycle_o <= 1'b0;
                    hit_r <= '0;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // timed controls toward the controllers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 1'b0;
            pre_sh_r <= '0;
            lat_addr_r <= '0;
            lat_ctl_r <= '0;
            dis_r <= 1'b0;
            rack_r <= 1'b0;
            prio_r <= 1'b0;
            data_select_o <= '0;
        end else begin
            // wait until the winner's address has crossed the synchroniser
            pre_sh_r <= {pre_sh_r[0], grant_steady};
            pre_r <= &pre_sh_r && grant_steady; // see R2
            if (latch_clk) begin
                lat_addr_r <= addr_s; // see R16
                lat_ctl_r <= ctl_s;
            end
            if (at30) begin
                dis_r <= 1'b1; // see R7
                data_select_o <= grant;
            end else if (at150) begin
                dis_r <= 1'b0; // see R11
            end
            if (state_r == S_DONE) begin
                data_select_o <= '0;
            end
            rack_r <= at60 ? 1'b1 : (at120 ? 1'b0 : rack_r); // see R9
            prio_r <= at120; // see R10
        end
    end

    // registered outputs toward memory bus and controllers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            address_select_to_winner_o <= '0;
            channel_combined_request_o <= 1'b0;
            channel_cycle_active_o <= 1'b0;
            addr_mux_select_high_o <= 1'b0;
            addr_mux_select_low_o <= 1'b1;
            mem_addr_o <= '0;
            memory_bus_op_bit1_o <= 1'b0;
            memory_bus_op_bit0_o <= 1'b0;
            word_select_o <= 1'b0;
            byte_select_o <= 1'b0;
            byte_write_op_o <= 1'b0;
            mem_data_o <= '0;
            mem_data_oe_o <= 1'b0;
        end else begin
            address_select_to_winner_o <= grant; // see R1
            channel_combined_request_o <= any_req;
            channel_cycle_active_o <= lock_r; // see R4
            addr_mux_select_high_o <= sel[1]; // see R17
            addr_mux_select_low_o <= sel[0];
            mem_addr_o <= mux_addr; // see R5
            memory_bus_op_bit1_o <= 1'b0; // see R20
            memory_bus_op_bit0_o <= mux_c1; // see R20
            word_select_o <= mux_addr[cache_wr_pkg::WORD_BIT]; // see R19
            byte_write_op_o <= mux_c1 && lat_ctl_r[1];
            byte_select_o <= mux_c1 && lat_ctl_r[1]
                && mux_addr[cache_wr_pkg::BYTE_BIT]; // see R19
            mem_data_o <= wd_s;
            mem_data_oe_o <= |data_select_o && !occ_s
                && state_r != S_DONE; // see R8
        end
    end

    assign priority_record_clock_o = prio_r;
    assign arb_disable_o = dis_r;
    assign cycle_lock_o = lock_r;
    assign init_busy_o = init_r;
    assign channel_request_ack_o = rack_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_lock_rise;
        $rose(lock_r);
    endsequence
    sequence s_bus_free_run;
        !occ_s [*3];
    endsequence

    a_start_gate: assert property (s_lock_rise |->
        $past(!read_pause_write_i && !iomap_precycle_i && pre_r)) // see R3
        else $error("cycle started while blocked");
    a_lock_cycle: assert property (lock_r |=> channel_cycle_active_o) // see R4
        else $error("channel cycle missing under lock");
    a_disable_t30: assert property (s_lock_rise |->
        ##D30 $rose(dis_r)) // see R7
        else $error("disable not raised at T30");
    a_ack_t60: assert property (s_lock_rise |->
        ##D60 $rose(rack_r)) // see R9
        else $error("request ack not at T60");
    a_prio_t120: assert property (s_lock_rise |->
        ##D120 prio_r ##1 !prio_r) // see R10
        else $error("priority clock not at T120");
    a_enable_t150: assert property (s_lock_rise |->
        ##D150 $fell(dis_r)) // see R11
        else $error("disable not dropped at T150");
    a_start_skew: assert property ($rose(mem_start_o) |->
        $past(slow_cycle_o) && $past(!occ_s)) // see R12
        else $error("start before skew");
    a_data_free: assert property (mem_data_oe_o |->
        $past(!occ_s)) // see R8
        else $error("data driven on occupied bus");
    a_addr_ack: assert property (state_r == S_ACK && ack_s |=>
        requester_address_ack_o ##1 !lock_r) // see R13 see R15
        else $error("no address ack after memory ack");
    a_tag_inval: assert property (twr_r |-> |hit_r && tag_wr == hit_r) // see R14
        else $error("tag write without hit");
    a_c1_low: assert property (!memory_bus_op_bit1_o) // see R20
        else $error("op bit 1 asserted");
    a_mux_chan: assert property (lock_r && !init_r |->
        sel == cache_wr_pkg::SEL_CHAN) // see R17
        else $error("wrong mux select in channel cycle");
    a_tmo_err: assert property (state_r == S_ACK && tmo_done && !ack_s
        |=> timeout_err_o && state_r == S_DONE) // see R21
        else $error("timeout not flagged");
    a_skew_run: assert property (s_bus_free_run ##0 state_r == S_SLOW
        && $past(state_r) == S_SLOW |-> skew_r != 8'h00) // see R12
        else $error("skew counter stalled");
endmodule : cache_chan_write

// File: rtl/cache_wr_pkg.sv
// constants shared by the channel write path
package cache_wr_pkg;
    localparam int CLK_NS = 20;
    localparam int T30_NS = 30;
    localparam int T60_NS = 60;
    localparam int T120_NS = 120;
    localparam int T150_NS = 150;
    localparam int T180_NS = 180;
    localparam int SKEW_NS = 100;
    localparam int TMO_NS = 10000;
    localparam int CYC_T30 = (T30_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_T60 = (T60_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_T120 = (T120_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_T150 = (T150_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_T180 = (T180_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_SKEW = (SKEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_TMO = TMO_NS / CLK_NS;
    localparam int ADDR_W = 22;
    localparam int IDX_LO = 2;
    localparam int IDX_HI = 9;
    localparam int IDX_W = 8;
    localparam int TAG_LO = 10;
    localparam int TAG_HI = 21;
    localparam int TAG_W = 12;
    localparam int PA_LO = 15;
    localparam int ENT_W = 15;
    localparam int ENT_VALID = 14;
    localparam int ENT_PA = 13;
    localparam int ENT_PB = 12;
    localparam int WORD_BIT = 1;
    localparam int BYTE_BIT = 0;
    localparam logic [1:0] SEL_CPU = 2'h0;
    localparam logic [1:0] SEL_INIT = 2'h1;
    localparam logic [1:0] SEL_CHAN = 2'h2;
    localparam logic [1:0] SEL_IOMAP = 2'h3;
    localparam logic [7:0] INIT_LAST = 8'h00ff;
    localparam logic [7:0] INIT_FIRST = 8'h0000;
endpackage : cache_wr_pkg

// File: rtl/channel_arbiter.sv
// rotating priority arbiter for the storage channel controllers
`timescale 1ns/100ps
module channel_arbiter #(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] req_i,
    input wire logic disable_i,
    input wire logic prio_clk_i,
    output logic [N-1:0] grant_o,
    output logic any_o
);
    localparam int IW = (N > 1) ? $clog2(N) : 1;
    logic [IW-1:0] last_r;
    logic [IW-1:0] grant_idx;
    logic [N-1:0] pick;
    logic [N-1:0] grant_r;
    int idx;
    always_comb begin
        pick = '0;
        idx = 0;
        for (int k = N; k >= 1; k--) begin
            idx = (int'(last_r) + k) % N;
            if (req_i[idx]) begin
                pick = '0;
                pick[idx] = 1'b1;
            end
        end
    end
    always_comb begin
        grant_idx = '0;
        for (int k = 0; k < N; k++) begin
            if (grant_r[k]) begin
                grant_idx = IW'(k);
            end
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            grant_r <= '0;
            last_r <= '0;
        end else begin
            if (!disable_i) begin
                grant_r <= pick;
            end
            if (prio_clk_i) begin
                last_r <= grant_idx;
            end
        end
    end
    assign grant_o = grant_r;
    assign any_o = |grant_r;
endmodule : channel_arbiter

// File: rtl/tag_store.sv
// two-way tag memory, one write strobe per way
`timescale 1ns/100ps
module tag_store #(
    parameter int IW = cache_wr_pkg::IDX_W,
    parameter int EW = cache_wr_pkg::ENT_W
) (
    input wire logic clk_i,
    input wire logic [IW-1:0] idx_i,
    input wire logic [1:0] wr_i,
    input wire logic [EW-1:0] wdata_i,
    output logic [EW-1:0] rd0_o,
    output logic [EW-1:0] rd1_o
);
    logic [EW-1:0] rd [2];
    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_way
            logic [EW-1:0] mem [2**IW];
            always_ff @(posedge clk_i) begin
                if (wr_i[w]) begin
                    mem[idx_i] <= wdata_i;
                end
            end
            assign rd[w] = mem[idx_i];
        end
    endgenerate
    assign rd0_o = rd[0];
    assign rd1_o = rd[1];
endmodule : tag_store

// File: sim/chan_mem_partner.sv
// storage controllers and main memory bus model
`timescale 1ns/100ps
module chan_mem_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] go_i,
    input wire logic [21:0] base_i,
    input wire logic c1_i,
    input wire logic c0_i,
    input wire logic noack_i,
    input wire logic [3:0] sel_i,
    input wire logic [3:0] dsel_i,
    input wire logic rack_i,
    input wire logic start_i,
    output logic [3:0] req_o,
    output logic [21:0] addr_o,
    output logic c1_o,
    output logic c0_o,
    output logic cx_o,
    output logic [35:0] wd_o,
    output logic busy_o,
    output logic ack_o
);
    logic [21:0] last_r;
    logic [4:0] busy_r;
    logic st_r;
    logic win;
    function automatic logic [21:0] ix(input logic [3:0] v);
        ix = {20'h0_0000, v[3] | v[2], v[3] | v[1]};
    endfunction : ix
    // undriven lines flip every cycle instead of holding
    assign win = |(sel_i & req_o);
    assign addr_o = win ? base_i + ix(sel_i) : ~last_r;
    assign c1_o = win ? c1_i : ~last_r[0];
    assign c0_o = win ? c0_i : last_r[0];
    assign cx_o = ~last_r[1];
    assign wd_o = |dsel_i ? {14'h0, base_i + ix(dsel_i)} : {14'h3fff, last_r};
    assign busy_o = |busy_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= 4'h0;
            last_r <= 22'h00_0000;
            busy_r <= 5'h00;
            st_r <= 1'b0;
            ack_o <= 1'b0;
        end else begin
            req_o <= (req_o | go_i) & ~(rack_i ? sel_i : 4'h0);
            last_r <= addr_o;
            busy_r <= |go_i ? 5'h1f : busy_r - {4'h0, busy_o};
            st_r <= start_i;
            ack_o <= start_i & st_r & ~noack_i;
        end
    end
endmodule : chan_mem_partner

// File: sim/cache_chan_write_tb_top.sv
// self-checking bench for the channel write path
`timescale 1ns/100ps
module cache_chan_write_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] go = 4'h0, req, grant, dsel, w1, w2;
    logic c1 = 1'b0, c0 = 1'b0, noack = 1'b0, rpw = 1'b0, iop = 1'b0;
    logic ioc = 1'b0;
    logic [21:0] base = 22'h15_a5a4, cpa = 22'h2b_3c4d, ioa = 22'h0e_1f20;
    logic [21:0] paddr, maddr;
    logic [35:0] pwd, mdata;
    logic pc1, pc0, pcx, busy, mack, creq, rack, prio, dis, cact, lock;
    logic s1, s0, op1, op0, wsel, bsel, bwo, moe, slow, mst, aack, terr;
    logic ibusy, twr;
    int n_fail = 0, num_checks = 0;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    chan_mem_partner far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .base_i(base), .c1_i(c1), .c0_i(c0), .noack_i(noack), .sel_i(grant),
        .dsel_i(dsel), .rack_i(rack), .start_i(mst), .req_o(req),
        .addr_o(paddr), .c1_o(pc1), .c0_o(pc0), .cx_o(pcx), .wd_o(pwd),
        .busy_o(busy), .ack_o(mack));
    cache_chan_write #(.N(4), .DATA_W(36), .TMO_CYC(20)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .chan_req_i(req), .chan_addr_i(paddr),
        .chan_c1_i(pc1), .chan_c0_i(pc0), .extra_op_control_bit_i(pcx),
        .chan_wdata_i(pwd), .cpu_addr_i(cpa), .iomap_addr_i(ioa),
        .iomap_cycle_i(ioc), .read_pause_write_i(rpw),
        .iomap_precycle_i(iop), .memory_bus_occupied_i(busy),
        .main_ack_i(mack), .address_select_to_winner_o(grant),
        .data_select_o(dsel), .channel_combined_request_o(creq),
        .channel_request_ack_o(rack), .priority_record_clock_o(prio),
        .arb_disable_o(dis), .channel_cycle_active_o(cact),
        .cycle_lock_o(lock), .addr_mux_select_high_o(s1),
        .addr_mux_select_low_o(s0), .mem_addr_o(maddr),
        .memory_bus_op_bit1_o(op1), .memory_bus_op_bit0_o(op0),
        .word_select_o(wsel), .byte_select_o(bsel), .byte_write_op_o(bwo),
        .mem_data_o(mdata), .mem_data_oe_o(moe), .slow_cycle_o(slow),
        .mem_start_o(mst), .requester_address_ack_o(aack), .tag_write_o(twr),
        .timeout_err_o(terr), .init_busy_o(ibusy));
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wait_lock(input logic v);
        int i;
        for (i = 0; i < 300 && lock !== v; i++) begin
            @(negedge clk_i);
        end
        if (lock !== v) begin
            chk("lock_wait", v, lock);
            summarize;
        end
    endtask : wait_lock
    task t_mux;
        @(posedge clk_i);
        ioc <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("mux_io", {2'h3, ioa}, {s1, s0, maddr});
        @(posedge clk_i);
        ioc <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("mux_cpu", {2'h0, cpa}, {s1, s0, maddr});
        $display("test mux done");
    endtask : t_mux
    task run_cycle(input logic [3:0] g, input logic a1, a0, na,
                   output logic [3:0] w);
        logic [21:0] ea;
        int n, fr, st, acks;
        @(posedge clk_i);
        go <= g;
        c1 <= a1;
        c0 <= a0;
        noack <= na;
        @(posedge clk_i);
        go <= 4'h0;
        wait_lock(1'b1);
        w = grant;
        ea = base + {20'h0_0000, w[3] | w[2], w[3] | w[1]};
        chk("grant", {1'b1, g & w}, {$onehot(w), w});
        chk("creq", 1, creq);
        for (n = 1; n <= 12; n++) begin
            @(negedge clk_i);
            chk("disable", n >= 2 && n < 8, dis);
            chk("req_ack", n >= 3 && n < 6, rack);
            chk("prio_clk", n == 6, prio);
            chk("slow", n >= 9, slow);
            chk("cyc_mux", 4'he, {lock, cact, s1, s0});
            chk("addr", ea, maddr);
            chk("op", {1'b0, a1}, {op1, op0});
            chk("word_byte", {ea[1], ea[0] & a1 & a0, a1 & a0},
                {wsel, bsel, bwo});
            if (n >= 2) chk("dsel", w, dsel);
            if (n >= 5) chk("oe_start", 0, {moe, mst});
        end
        fr = -1;
        st = 0;
        acks = 0;
        for (n = 0; n < 200 && lock === 1'b1; n++) begin
            @(negedge clk_i);
            if (busy === 1'b0 && fr < 0) fr = n;
            if (mst === 1'b1 && st == 0) begin
                st = 1;
                chk("skew", 1, n - fr >= 5 && n - fr <= 9);
                chk("data_oe", 1, moe);
                chk("wdata", {14'h0, ea}, mdata);
            end
            acks += (aack === 1'b1);
            chk("tag_wr", 0, twr);
        end
        @(negedge clk_i);
        chk("finish", {2'h0, 1'b1}, {lock, cact, st[0]});
        chk("addr_ack", !na, acks);
        chk("timeout", na, terr);
        $display("test cycle done");
    endtask : run_cycle
    task t_block;
        int k, i;
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            rpw <= (k == 0);
            iop <= (k == 1);
            go <= 4'h1;
            @(posedge clk_i);
            go <= 4'h0;
            for (i = 0; i < 30; i++) begin
                @(negedge clk_i);
                chk("blocked", 0, lock);
            end
            @(posedge clk_i);
            rpw <= 1'b0;
            iop <= 1'b0;
            wait_lock(1'b1);
            wait_lock(1'b0);
        end
        $display("test block done");
    endtask : t_block
    initial begin
        repeat (11) @(posedge clk_i);
        @(negedge clk_i);
        chk("reset", 4'h3, {lock, aack, s0, ibusy});
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (250) @(negedge clk_i);
        chk("init_busy", 1, ibusy);
        repeat (15) @(negedge clk_i);
        chk("init_done", 0, ibusy);
        t_mux;
        run_cycle(4'h1, 1'b1, 1'b0, 1'b0, w1);
        run_cycle(4'h2, 1'b1, 1'b1, 1'b0, w1);
        run_cycle(4'h4, 1'b0, 1'b0, 1'b0, w1);
        t_block;
        run_cycle(4'h6, 1'b1, 1'b0, 1'b0, w1);
        run_cycle(4'h6 & ~w1, 1'b1, 1'b0, 1'b0, w2);
        chk("next_winner", 4'h6 & ~w1, w2);
        run_cycle(4'h8, 1'b1, 1'b0, 1'b1, w1);
        summarize;
    end
endmodule : cache_chan_write_tb_top
